// File: hdl/ets_tx_sig_ctrl.sv
/*
 * E1 transmit signaling controller: frame FIFO, HDLC/SS7/transparent source,
 * spare bit and CAS insertion on the transmit system highway.
 * Assumes highway clock, sync and data pins are asynchronous to i_clk and
 * much slower; software drives the control ports from the i_clk domain.
 */
module ets_tx_sig_ctrl (
  input wire logic i_clk,                               // System clock 20 MHz
  input wire logic i_rst_n,                             // Async reset
  input wire logic i_system_tx_clock,                   // Highway clock pin
  input wire logic i_tx_sync_pulse_n,                   // Frame sync pin
  input wire logic i_system_tx_data_input,              // Highway data pin
  input wire logic i_serial_signaling_input,            // Highway signaling pin
  input wire ets_pkg::ets_mode_t i_sc_mode,             // Controller mode
  input wire logic i_transp_cont,                       // Repeat in transparent
  input wire logic i_auto_fill_unit_enable,             // SS7 fill units
  input wire logic [7:0] i_idle_code,                   // Interframe idle
  input wire logic i_fifo_wr,                           // FIFO write strobe
  input wire logic [7:0] i_fifo_wdata,                  // FIFO write byte
  input wire logic i_fifo_commit,                       // Frame complete
  input wire logic i_fifo_updating,                     // Software busy
  input wire logic i_repeat_send_command,               // Repeat strobe
  input wire logic i_tx_and_ctrl_reset_commands,        // Reset strobe
  input wire logic [31:0] i_ch1_slots,                  // Channel 1 slots
  input wire logic i_ch2_en,                            // Channel 2 on
  input wire logic [4:0] i_ch2_slot,                    // Channel 2 slot
  input wire logic [7:0] i_ch2_data,                    // Channel 2 byte
  input wire logic i_ch3_en,                            // Channel 3 on
  input wire logic [4:0] i_ch3_slot,                    // Channel 3 slot
  input wire logic [7:0] i_ch3_data,                    // Channel 3 byte
  input wire ets_pkg::ets_sa_src_t i_spare_bit_src,     // Spare bit source
  input wire logic [4:0] i_spare_bit_select_field,      // Bits 4..8 mask
  input wire logic [4:0] i_spare_bit_word_reg,          // Single word
  input wire logic [39:0] i_spare_bit_multiframe_regs,  // Per frame set
  input wire logic i_cas_serial_en,                     // Serial CAS
  input wire logic i_cas_up_en,                         // Processor CAS
  input wire logic i_ext_sig_en,                        // System side insert
  input wire logic i_mf_mode,                           // Multiframe mode
  input wire logic [127:0] i_cas_signaling_regs,        // Slot 16 bytes
  output logic o_tx_data,                               // Transmit path bit
  output logic o_sig_out,                               // Signaling pin out
  output logic [6:0] o_fifo_count,                      // Bytes held
  output logic o_fifo_full,                             // FIFO full
  output logic o_frame_pending,                         // Frame committed
  output logic o_repeating                              // Repeat active
);
  import ets_pkg::*;

  ets_ser_if ser_if ();

  logic [2:0] ck_s, sy_s, di_s, sg_s;
  logic rise;
  logic [7:0] pos_q, cur_pos;
  logic [3:0] fr_q, cur_fr;
  logic [4:0] slot;
  logic [2:0] p, sa_i;
  logic [7:0] fifo_mem [64];
  logic [7:0] cas_mem [32];
  logic [6:0] wr_cnt_q;
  logic [5:0] rd_q;
  logic rdy_q, rep_q, up_act_q;
  logic [7:0] fsn_q, bsn_q;
  logic [1:0] fisu_q;
  logic [127:0] up_snap_q;
  logic frm_go, fisu_go, srcf, cap_wr, tx_d, sg_d;
  logic ch1_hit, sa_pos, sa_hit, up_bit, ser_cas_bit, none_cfg;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: stage 0 feeds stage 1 only, stage 2 is edge history
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ck_s <= 3'h0;
      sy_s <= 3'h7;
      di_s <= 3'h0;
      sg_s <= 3'h0;
    end else begin
      ck_s <= {ck_s[1:0], i_system_tx_clock};
      sy_s <= {sy_s[1:0], i_tx_sync_pulse_n};
      di_s <= {di_s[1:0], i_system_tx_data_input};
      sg_s <= {sg_s[1:0], i_serial_signaling_input};
    end
  end

  assign rise = ck_s[1] && !ck_s[2];
  assign cur_pos = !sy_s[1] ? POS_FIRST : pos_q + 8'h01;
  assign cur_fr = !sy_s[1] ? MF_FIRST_FRAME : (pos_q == POS_LAST ? fr_q + 4'h1 : fr_q);
  assign slot = cur_pos[7:3];
  assign p = cur_pos[2:0];

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pos_q <= POS_LAST;
      fr_q <= MF_LAST_FRAME;
    end else if (rise) begin
      pos_q <= cur_pos;
      fr_q <= cur_fr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame FIFO; writes are refused while a frame is committed
  always_ff @(posedge i_clk) begin
    if (i_fifo_wr && !rdy_q && wr_cnt_q != FIFO_FULL_CNT) begin
      fifo_mem[wr_cnt_q[5:0]] <= i_fifo_wdata;
    end
  end

  assign frm_go = rdy_q && !(rd_q == 6'h00 && i_fifo_updating);
  assign fisu_go = i_sc_mode == ETS_MODE_SS7 && i_auto_fill_unit_enable && !rdy_q;
  assign srcf = fisu_q == FISU_BSN_IDX && frm_go;

  always_comb begin
    ser_if.bvalid = srcf || fisu_go || fisu_q != FISU_BSN_IDX;
    ser_if.bdata = fifo_mem[rd_q];
    ser_if.blast = {1'b0, rd_q} + 7'h01 == wr_cnt_q;
    if (!srcf) begin
      ser_if.blast = fisu_q == FISU_LAST_IDX;
      case (fisu_q)
        FISU_BSN_IDX: ser_if.bdata = bsn_q;
        FISU_FSN_IDX: ser_if.bdata = fsn_q;
        default: ser_if.bdata = FISU_LI;
      endcase
    end
  end

  assign ser_if.flush = i_tx_and_ctrl_reset_commands;
  assign ser_if.transp = i_sc_mode == ETS_MODE_TRANSP;
  assign ser_if.idle = i_idle_code;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_cnt_q <= 7'h00;
      rd_q <= 6'h00;
      rdy_q <= 1'b0;
      rep_q <= 1'b0;
      fisu_q <= FISU_BSN_IDX;
    end else if (i_tx_and_ctrl_reset_commands) begin
      wr_cnt_q <= 7'h00;
      rd_q <= 6'h00;
      rdy_q <= 1'b0;
      rep_q <= 1'b0;
      fisu_q <= FISU_BSN_IDX;
    end else begin
      if (i_fifo_wr && !rdy_q && wr_cnt_q != FIFO_FULL_CNT) begin
        wr_cnt_q <= wr_cnt_q + 7'h01;
      end
      if (i_fifo_commit && wr_cnt_q != 7'h00) begin
        rdy_q <= 1'b1;
      end
      if (i_repeat_send_command) begin
        rep_q <= 1'b1;
      end
      if (ser_if.bready && srcf) begin
        rd_q <= ser_if.blast ? 6'h00 : rd_q + 6'h01;
        if (ser_if.blast && !(rep_q || (ser_if.transp && i_transp_cont))) begin
          rdy_q <= 1'b0;
          wr_cnt_q <= 7'h00;
        end
      end else if (ser_if.bready) begin
        fisu_q <= ser_if.blast ? FISU_BSN_IDX : fisu_q + 2'h1;
      end
    end
  end

  // Sequence numbers of the last unit sent from the FIFO
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bsn_q <= 8'h00;
      fsn_q <= 8'h00;
    end else if (ser_if.bready && srcf && ser_if.blast) begin
      bsn_q <= fifo_mem[0];
      fsn_q <= fifo_mem[1];
    end
  end

  ets_hdlc_ser u_ser (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .s(ser_if)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Slot decode
  assign ch1_hit = i_ch1_slots[slot];
  assign sa_pos = slot == TS_FRAMING && cur_fr[0] && p >= SA_FIRST_POS;
  assign sa_i = p - SA_FIRST_POS;
  assign sa_hit = sa_pos && i_spare_bit_select_field[sa_i];
  assign ser_if.take = rise && (ch1_hit || (sa_hit && i_spare_bit_src == ETS_SA_FIFO));
  assign none_cfg = i_ch1_slots == 32'h0 && !i_ch2_en && !i_ch3_en && !i_cas_serial_en
                    && !i_cas_up_en && i_spare_bit_select_field == 5'h00;

  // Serial CAS capture: multiframe mode reads the last frame only
  assign cap_wr = rise && i_cas_serial_en && (!i_mf_mode || cur_fr == MF_LAST_FRAME)
                  && (p >= SIG_FIRST_POS || slot == TS_FRAMING || slot == TS_CAS);

  // Cleared so slot 16 never carries unknowns before the first capture
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < $size(cas_mem); i++) begin
        cas_mem[i] <= 8'h00;
      end
    end else if (cap_wr) begin
      cas_mem[slot][MSB_POS - p] <= sg_s[1];
    end
  end

  // Slot 16 carries nibbles of slots f and f+16 in frame f for frames 1 to 15; frame 0 carries the captured slot 16 byte
  always_comb begin
    if (cur_fr == MF_FIRST_FRAME) begin
      ser_cas_bit = bit_at(cas_mem[TS_CAS], p);
    end else if (p < SIG_FIRST_POS) begin
      ser_cas_bit = bit_at(cas_mem[{1'b0, cur_fr}], p + SIG_FIRST_POS);
    end else begin
      ser_cas_bit = bit_at(cas_mem[{1'b1, cur_fr}], p);
    end
  end

  // Processor CAS snapshot is taken on a multiframe boundary only
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      up_act_q <= 1'b0;
      up_snap_q <= 128'h0;
    end else if (!i_cas_up_en) begin
      up_act_q <= 1'b0;
    end else if (rise && cur_pos == POS_FIRST && cur_fr == MF_FIRST_FRAME) begin
      up_act_q <= 1'b1;
      up_snap_q <= i_cas_signaling_regs;
    end
  end

  assign up_bit = bit_at(up_snap_q[{cur_fr, 3'h0} +: 8], p);

  ////////////////////////////////////////////////////////////////////////////
  // Output mux; later assignments win
  always_comb begin
    tx_d = di_s[1];
    sg_d = sg_s[1];
    if (i_cas_serial_en && slot == TS_CAS) begin
      tx_d = ser_cas_bit;
    end
    if (up_act_q && slot == TS_CAS) begin
      if (i_ext_sig_en) begin
        sg_d = up_bit;
      end else begin
        tx_d = up_bit;
      end
    end
    if (i_ch2_en && slot == i_ch2_slot) begin
      tx_d = bit_at(i_ch2_data, p);
    end
    if (i_ch3_en && slot == i_ch3_slot) begin
      tx_d = bit_at(i_ch3_data, p);
    end
    if (ser_if.take) begin
      if (i_ext_sig_en) begin
        sg_d = ser_if.bit_o;
      end else begin
        tx_d = ser_if.bit_o;
      end
    end
    if (sa_hit && i_spare_bit_src == ETS_SA_WORD) begin
      tx_d = i_spare_bit_word_reg[MSB_POS - p];
    end
    if (sa_hit && i_spare_bit_src == ETS_SA_MULTI) begin
      tx_d = i_spare_bit_multiframe_regs[{sa_i, cur_fr[3:1]}];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_tx_data <= 1'b0;
      o_sig_out <= 1'b0;
    end else if (rise) begin
      o_tx_data <= tx_d;
      o_sig_out <= sg_d;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_fifo_full <= 1'b0;
    end else begin
      o_fifo_full <= wr_cnt_q == FIFO_FULL_CNT;
    end
  end

  assign o_fifo_count = wr_cnt_q;
  assign o_frame_pending = rdy_q;
  assign o_repeating = rep_q;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_fifo_full_hold: assert property (
    (wr_cnt_q == FIFO_FULL_CNT && !i_tx_and_ctrl_reset_commands && !rdy_q)
    |=> wr_cnt_q == FIFO_FULL_CNT)
    else $error("full FIFO count changed without reset");
  a_pass_through: assert property (
    (rise && none_cfg) |=> o_tx_data == $past(di_s[1]))
    else $error("data altered with no signaling configured");
  a_update_pause: assert property (
    (i_fifo_updating && rd_q == 6'h00 && fisu_q == FISU_BSN_IDX) |-> !(ser_if.bready && srcf))
    else $error("frame started during software update");
  a_repeat_keep: assert property (
    (rep_q && rdy_q && !i_tx_and_ctrl_reset_commands) |=> (rep_q && rdy_q))
    else $error("repetition ended without reset command");
  a_reset_stop: assert property (
    i_tx_and_ctrl_reset_commands |=> (!rep_q && !rdy_q && wr_cnt_q == 7'h00))
    else $error("reset command did not stop sending");
  a_fisu_source: assert property (
    (ser_if.bready && !srcf) |-> (fisu_go || fisu_q != FISU_BSN_IDX))
    else $error("fill unit sent while not enabled");
  a_sig_ignore: assert property (
    (rise && p < SIG_FIRST_POS && slot != TS_FRAMING && slot != TS_CAS)
    |=> cas_mem[$past(slot)] == $past(cas_mem[slot]))
    else $error("signaling bits 1 to 4 were latched");
  a_mf_capture: assert property (
    (rise && i_mf_mode && cur_fr != MF_LAST_FRAME) |=> cas_mem[$past(slot)] == $past(cas_mem[slot]))
    else $error("serial CAS read outside last frame");
  a_up_line_side: assert property (
    (rise && up_act_q && !i_ext_sig_en && slot == TS_CAS && !ser_if.take
     && !(i_ch2_en && slot == i_ch2_slot) && !(i_ch3_en && slot == i_ch3_slot))
    |=> o_tx_data == $past(up_bit))
    else $error("processor CAS not on line side");
  a_sa_masked: assert property (
    (rise && sa_pos && !sa_hit && !ch1_hit && !(i_ch2_en && slot == i_ch2_slot)
     && !(i_ch3_en && slot == i_ch3_slot)) |=> o_tx_data == $past(di_s[1]))
    else $error("unselected spare bit was replaced");

  c_frame_done: cover property (ser_if.bready && srcf && ser_if.blast);
  c_repeat: cover property (rep_q && ser_if.bready && srcf && ser_if.blast);
  c_fisu: cover property (ser_if.bready && !srcf && ser_if.blast);
  c_cas_cap: cover property (cap_wr && i_mf_mode);
endmodule : ets_tx_sig_ctrl

// File: hdl/ets_pkg.sv
/*
 * Shared constants and types for the E1 transmit signaling controller.
 * Assumes one system clock; all link timing is derived from sampled pins.
 */
package ets_pkg;
  localparam logic [6:0] FIFO_FULL_CNT = 7'h40;
  localparam logic [7:0] HDLC_FLAG = 8'h7E;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'h8408;
  localparam logic [2:0] STUFF_RUN = 3'h5;
  localparam logic [4:0] BYTE_BITS = 5'h08;
  localparam logic [4:0] CRC_BITS = 5'h10;
  localparam logic [4:0] LAST_BIT = 5'h01;
  localparam logic [4:0] TS_FRAMING = 5'h00;
  localparam logic [4:0] TS_CAS = 5'h10;
  localparam logic [2:0] MSB_POS = 3'h7;
  localparam logic [2:0] SA_FIRST_POS = 3'h3;
  localparam logic [2:0] SIG_FIRST_POS = 3'h4;
  localparam logic [3:0] MF_FIRST_FRAME = 4'h0;
  localparam logic [3:0] MF_LAST_FRAME = 4'hF;
  localparam logic [7:0] POS_FIRST = 8'h00;
  localparam logic [7:0] POS_LAST = 8'hFF;
  localparam logic [7:0] FISU_LI = 8'h00;
  localparam logic [1:0] FISU_BSN_IDX = 2'h0;
  localparam logic [1:0] FISU_FSN_IDX = 2'h1;
  localparam logic [1:0] FISU_LAST_IDX = 2'h2;

  typedef enum logic [1:0] {ETS_MODE_HDLC, ETS_MODE_TRANSP, ETS_MODE_SS7} ets_mode_t;
  typedef enum logic [1:0] {ETS_SA_WORD, ETS_SA_MULTI, ETS_SA_FIFO} ets_sa_src_t;

  // Bit 1 of a time slot goes first on the highway
  function automatic logic bit_at(input logic [7:0] b, input logic [2:0] p);
    return b[MSB_POS - p];
  endfunction : bit_at
endpackage : ets_pkg

// File: hdl/ets_ser_if.sv
/*
 * Carrier between the frame source and the HDLC bit serializer.
 * Assumes both ends run on the same system clock.
 */
interface ets_ser_if;
  logic take;
  logic bit_o;
  logic flush;
  logic transp;
  logic [7:0] idle;
  logic bvalid;
  logic [7:0] bdata;
  logic blast;
  logic bready;
  modport src (output take, flush, transp, idle, bvalid, bdata, blast, input bit_o, bready);
  modport ser (input take, flush, transp, idle, bvalid, bdata, blast, output bit_o, bready);
endinterface : ets_ser_if

// File: hdl/ets_hdlc_ser.sv
/*
 * HDLC bit serializer: flags, CRC16, zero insertion, idle code, transparent bytes.
 * Assumes a take pulse per outgoing bit and bytes offered with valid/ready.
 */
module ets_hdlc_ser (
  input wire logic i_clk,   // System clock
  input wire logic i_rst_n, // Async reset, active low
  ets_ser_if.ser s          // Byte in, bit out
);
  import ets_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_OPEN, ST_DATA, ST_CRC} ets_ser_st_t;

  ets_ser_st_t st_q, st_d;
  logic [15:0] sh_q, sh_d, crc_q, crc_d, crc_n;
  logic [4:0] cnt_q, cnt_d;
  logic [2:0] ones_q;
  logic last_q;
  logic stuff_now, shift, crc_on, stuff_on;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
    return (c[0] ^ b) ? ({1'b0, c[15:1]} ^ CRC_POLY) : {1'b0, c[15:1]};
  endfunction : crc_step

  ////////////////////////////////////////////////////////////////////////////
  assign stuff_now = ones_q == STUFF_RUN;
  assign s.bit_o = stuff_now ? 1'b0 : sh_q[0];
  assign shift = s.take && !stuff_now;
  assign crc_on = st_q == ST_DATA && !s.transp;
  assign stuff_on = (st_q == ST_DATA || st_q == ST_CRC) && !s.transp;
  assign crc_n = crc_step(crc_q, sh_q[0]);

  always_comb begin
    st_d = st_q;
    sh_d = sh_q;
    cnt_d = cnt_q;
    crc_d = crc_q;
    s.bready = 1'b0;
    if (shift) begin
      sh_d = {1'b0, sh_q[15:1]};
      cnt_d = cnt_q - LAST_BIT;
      if (crc_on) begin
        crc_d = crc_n;
      end
      if (cnt_q == LAST_BIT) begin
        sh_d = {8'h00, s.idle};
        cnt_d = BYTE_BITS;
        case (st_q)
          ST_IDLE: begin
            if (s.bvalid && s.transp) begin
              sh_d = {8'h00, s.bdata};
              s.bready = 1'b1;
              st_d = ST_DATA;
            end else if (s.bvalid) begin
              sh_d = {8'h00, HDLC_FLAG};
              st_d = ST_OPEN;
            end
          end
          ST_OPEN: begin
            if (s.bvalid) begin
              sh_d = {8'h00, s.bdata};
              s.bready = 1'b1;
              crc_d = CRC_INIT;
              st_d = ST_DATA;
            end else begin
              sh_d = {8'h00, HDLC_FLAG};
            end
          end
          ST_DATA: begin
            if (!s.transp && last_q) begin
              sh_d = ~crc_n;
              cnt_d = CRC_BITS;
              st_d = ST_CRC;
            end else if (s.bvalid) begin
              sh_d = {8'h00, s.bdata};
              s.bready = 1'b1;
            end else if (!s.transp) begin
              sh_d = {8'h00, HDLC_FLAG};
              st_d = ST_IDLE;
            end else begin
              st_d = ST_IDLE;
            end
          end
          ST_CRC: begin
            sh_d = {8'h00, HDLC_FLAG};
            st_d = ST_IDLE;
          end
          default: st_d = ST_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= ST_IDLE;
      sh_q <= {8'h00, HDLC_FLAG};
      cnt_q <= BYTE_BITS;
      crc_q <= CRC_INIT;
      last_q <= 1'b0;
    end else if (s.flush) begin
      st_q <= ST_IDLE;
      sh_q <= {8'h00, HDLC_FLAG};
      cnt_q <= BYTE_BITS;
      last_q <= 1'b0;
    end else begin
      st_q <= st_d;
      sh_q <= sh_d;
      cnt_q <= cnt_d;
      crc_q <= crc_d;
      if (s.bready) begin
        last_q <= s.blast;
      end
    end
  end

  // Zero insertion after five ones, carried across a state change
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ones_q <= 3'h0;
    end else if (s.flush) begin
      ones_q <= 3'h0;
    end else if (s.take) begin
      if (stuff_now || !stuff_on || !sh_q[0]) begin
        ones_q <= 3'h0;
      end else begin
        ones_q <= ones_q + 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_ones_bounded: assert property (
    ones_q <= STUFF_RUN)
    else $error("stuffing run exceeded five ones");
  a_open_flag: assert property (
    (st_q == ST_IDLE && shift && cnt_q == LAST_BIT && s.bvalid && !s.transp && !s.flush)
    |=> (st_q == ST_OPEN && sh_q[7:0] == HDLC_FLAG))
    else $error("frame did not open with a flag");
  a_transp_raw: assert property (
    (s.transp && st_q == ST_DATA && s.take) |-> s.bit_o == sh_q[0])
    else $error("transparent data was altered");
endmodule : ets_hdlc_ser

// File: verif/ets_hwy_model.sv
/* Transmit highway model: clock, frame sync, payload and signaling pins.
   Assumes the bench sets the payload byte; counting starts at frame 0. */
module ets_hwy_model (
  input wire logic i_run,        // Clock runs while high
  input wire logic [7:0] i_byte, // Byte in every slot
  output logic o_hclk,           // Highway clock, 400 ns
  output logic o_sync_n,         // Multiframe sync, one bit wide
  output logic o_dat,            // Payload bit
  output logic o_sig,            // Signaling bit
  output logic [7:0] o_pos,      // Bit in frame
  output logic [3:0] o_frm       // Frame in multiframe
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {o_hclk, o_sync_n, o_dat, o_sig, o_frm, o_pos} = {4'h4, 12'hFFF};
    forever begin
      #200 o_hclk = 1'b0;
      // Change on the falling edge so the rising edge sees settled pins
      if (i_run) begin
        {o_frm, o_pos} = {o_frm, o_pos} + 12'h001;
        o_sync_n = ({o_frm, o_pos} != 12'h000);
        o_dat = i_byte[3'h7 - o_pos[2:0]];
        o_sig = ~o_dat;
      end
      #200 o_hclk = i_run;
    end
  end
endmodule : ets_hwy_model

// File: verif/tb_top.sv
/* Bench for the transmit signaling controller: highway stream and FIFO.
   Assumes the highway model and a 20 MHz system clock. */
`define CHK(n, g, e) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
  $display("BAD %s exp %0h got %0h", n, e, g); end end
module tb_top import ets_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] C2 = 8'hA5;
  typedef struct packed {logic [7:0] b; logic c2; logic [4:0] s;} ets_row_t;
  ets_row_t rows [5] = '{'{8'h00, 1'b0, 5'h00}, '{8'hFF, 1'b0, 5'h00},
    '{8'h3C, 1'b1, 5'h00}, '{8'h00, 1'b0, 5'h15}, '{8'h5A, 1'b1, 5'h1F}};
  logic i_clk = 1'b0, i_rst_n = 1'b0, run = 1'b0, chk = 1'b0, exp_b = 1'b0;
  logic wr = 1'b0, cmt = 1'b0, rpt = 1'b0, rcmd = 1'b0, c2en = 1'b0;
  logic hclk, sync_n, dat, sig, tx, full, pend, rep;
  logic [7:0] pbyte = 8'h00, wdat = 8'h00, pos;
  logic [4:0] sel = 5'h00;
  logic [3:0] frm;
  logic [6:0] cnt;
  logic [127:0] z = 128'h0;
  logic [31:0] ch1 = 32'h0;
  logic [7:0] got = 8'h00, ppos = 8'h00;
  logic upd = 1'b0, sgo, exp_s = 1'b0;
  ets_mode_t mode = ETS_MODE_HDLC;
  ets_sa_src_t src = ETS_SA_WORD;
  int error_cnt = 0, comparisons = 0, k = 0;
  ////////////////////////////////////////////////////////////////////////
  ets_hwy_model hwy (.i_run(run), .i_byte(pbyte), .o_hclk(hclk), .o_sync_n(sync_n),
    .o_dat(dat), .o_sig(sig), .o_pos(pos), .o_frm(frm));
  ets_tx_sig_ctrl dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_system_tx_clock(hclk),
    .i_tx_sync_pulse_n(sync_n), .i_system_tx_data_input(dat),
    .i_serial_signaling_input(sig), .i_sc_mode(mode), .i_transp_cont(z[0]),
    .i_auto_fill_unit_enable(z[1]), .i_idle_code(8'h7E), .i_fifo_wr(wr),
    .i_fifo_wdata(wdat), .i_fifo_commit(cmt), .i_fifo_updating(upd),
    .i_repeat_send_command(rpt), .i_tx_and_ctrl_reset_commands(rcmd),
    .i_ch1_slots(ch1), .i_ch2_en(c2en), .i_ch2_slot(5'h05), .i_ch2_data(C2),
    .i_ch3_en(z[3]), .i_ch3_slot(z[8:4]), .i_ch3_data(z[16:9]), .i_spare_bit_src(src),
    .i_spare_bit_select_field(sel), .i_spare_bit_word_reg(5'h1F),
    .i_spare_bit_multiframe_regs(z[39:0]), .i_cas_serial_en(z[4]), .i_cas_up_en(z[5]),
    .i_ext_sig_en(z[6]), .i_mf_mode(z[7]), .i_cas_signaling_regs(z),
    .o_tx_data(tx), .o_sig_out(sgo), .o_fifo_count(cnt), .o_fifo_full(full),
    .o_frame_pending(pend), .o_repeating(rep));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic exp_of(input logic [7:0] p, input logic [3:0] f, input logic d);
    if (c2en && p[7:3] == 5'h05) return C2[3'h7 - p[2:0]];
    if (p[7:3] == 5'h00 && f[0] && p[2:0] >= 3'h3) return sel[p[2:0] - 3'h3] ? 1'b1 : d;
    return d;
  endfunction : exp_of
  task automatic give_verdict();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict
  // Slot 3 byte of the frame is complete once bit 128 is on the pins
  task automatic next_frame();
    do @(posedge hclk); while (pos != 8'h80);
  endtask : next_frame
  initial forever #25 i_clk = ~i_clk;
  initial begin
    #3_000_000;
    error_cnt++;
    give_verdict();
  end
  // Bit k is judged at rise k+1, when the device has had time to drive it
  always @(posedge hclk) begin
    if (chk) `CHK("tx_data", tx, exp_b)
    if (chk) `CHK("sig_out", sgo, exp_s)
    exp_b <= exp_of(pos, frm, dat);
    exp_s <= sig;
    ppos <= pos;
    // Channel 1 slot 3 gathered LSB first, one bit behind the pins
    if (ppos[7:3] == 5'h03) got <= {tx, got[7:1]};
  end
  initial begin
    repeat (12) @(negedge i_clk);
    `CHK("count_rst", cnt, 7'h00)
    i_rst_n = 1'b1;
    repeat (2) @(negedge i_clk);
    run = 1'b1;
    foreach (rows[r]) begin
      {pbyte, c2en, sel} = rows[r];
      chk = 1'b0;
      repeat (3) @(negedge hclk);
      chk = 1'b1;
      repeat (520) @(negedge hclk);
    end
    chk = 1'b0;
    repeat (65) begin
      wdat = wdat + 8'h01;
      wr = 1'b1;
      @(negedge i_clk);
    end
    wr = 1'b0;
    repeat (2) @(negedge i_clk);
    `CHK("count", cnt, 7'h40)
    `CHK("full", full, 1'b1)
    cmt = 1'b1;
    @(negedge i_clk);
    cmt = 1'b0;
    rpt = 1'b1;
    @(negedge i_clk);
    rpt = 1'b0;
    repeat (2) @(negedge i_clk);
    `CHK("pending", pend, 1'b1)
    `CHK("repeat", rep, 1'b1)
    rcmd = 1'b1;
    @(negedge i_clk);
    rcmd = 1'b0;
    repeat (2) @(negedge i_clk);
    `CHK("cleared", {cnt, full, pend, rep}, 10'h000)
    // Transparent frame on slot 3, first held back by a software update
    next_frame();
    @(negedge i_clk);
    mode = ETS_MODE_TRANSP;
    ch1 = 32'h0000_0008;
    upd = 1'b1;
    wr = 1'b1;
    wdat = 8'hB1;
    @(negedge i_clk);
    wdat = 8'h2E;
    @(negedge i_clk);
    wr = 1'b0;
    cmt = 1'b1;
    @(negedge i_clk);
    cmt = 1'b0;
    repeat (2) next_frame();
    `CHK("tp_held", got, 8'h7E)
    `CHK("tp_pend", pend, 1'b1)
    @(negedge i_clk);
    upd = 1'b0;
    do begin
      next_frame();
      k++;
    end while (got !== 8'hB1 && k < 4);
    `CHK("tp_first", got, 8'hB1)
    next_frame();
    `CHK("tp_second", got, 8'h2E)
    next_frame();
    `CHK("tp_idle", got, 8'h7E)
    `CHK("tp_done", pend, 1'b0)
    give_verdict();
  end
endmodule : tb_top
